// *** logic/ulpm_map.vh ***
// Register offsets, field positions and reset values of the LPM status block.
`ifndef ULPM_MAP_VH
`define ULPM_MAP_VH
`define ULPM_OFF_STATUS 12'h000
`define ULPM_OFF_EVENT 12'h004
`define ULPM_OFF_CTRL 12'h008
`define ULPM_ADDR_MSB 14
`define ULPM_ADDR_LSB 8
`define ULPM_BIT_ERR 5
`define ULPM_BIT_RES 4
`define ULPM_BIT_NC 3
`define ULPM_BIT_ACK 2
`define ULPM_BIT_NYET 1
`define ULPM_BIT_STALL 0
`define ULPM_RST_ADDR 7'h00
`define ULPM_RST_FLAGS 6'h00
`define ULPM_HS_ACK 2'h0
`define ULPM_HS_NYET 2'h1
`define ULPM_HS_STALL 2'h2
`define ULPM_HS_NONE 2'h3
`endif

// *** logic/ulpm_status.v ***
// LPM status and function address register block behind an AHB-Lite slave.
// Operation
// - Seven-bit read/write function address at bits 14:8, reset to zero.
// - Device mode: unsupported link state sets error flag bit 5, answer STALL.
// - Resume flag bit 4 sets whenever the controller leaves suspend.
// - Device mode: pending receive data gives NYET and sets NC flag bit 3.
// - Host mode: ACK to our LPM transaction sets NC flag bit 3.
// - Device mode: LPM received and answered ACK sets ACK flag bit 2.
// - Host mode: peer ACKs our LPM transaction, ACK flag bit 2 sets.
// - Device mode: LPM received and answered NYET sets NYET flag bit 1.
// - Host mode: peer answers NYET, NYET flag bit 1 sets.
// - Unused bits 31:15 and 7:6 of the status register read zero.
`timescale 1ns/1ps
`include "ulpm_map.vh"
module ulpm_status (
  // Clock, reset and enable.
  input wire i_clock,
  input wire i_rst,
  input wire i_ce,
  // AHB-Lite slave.
  input wire i_hsel,
  input wire [11:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // Controller events, same clock domain; i_lpm_rx and i_lpm_tx_done are one-cycle pulses, the rest are levels.
  input wire i_host_mode,
  input wire i_lpm_rx,
  input wire i_linkstate_ok,
  input wire i_lpm_tx_done,
  input wire [1:0] i_peer_hs,
  // USB line state levels from the pins.
  input wire i_suspended,
  input wire i_rx_fifo_pending,
  // Handshake the device-mode controller must send.
  output reg o_hs_valid,
  output reg [1:0] o_hs_code,
  output reg [6:0] o_lpm_function_address
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DATA = 1'b1;

  reg state_r;
  reg wr_r;
  reg [11:0] addr_r;
  reg [6:0] addr_fld_r;
  reg [5:0] flags_r;
  reg [5:0] flags_nxt;
  reg susp_d_r;
  wire [1:0] pin_sync;
  wire suspended_s;
  wire pending_s;
  reg [5:0] set_v;
  reg [5:0] clr_v;
  reg [1:0] hs_nxt;

  ulpm_sync #(.W(2)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_suspended, i_rx_fifo_pending}),
    .o_sync(pin_sync)
  );
  assign suspended_s = pin_sync[1];
  assign pending_s = pin_sync[0];

  function [31:0] status_word;
    input [6:0] a;
    input [5:0] f;
    begin
      status_word = {17'h00000, a, 2'h0, f};
    end
  endfunction

  // Handshake selection and flag set terms for this cycle.
  always @* begin
    set_v = 6'h00;
    hs_nxt = `ULPM_HS_NONE;
    if (!i_host_mode && i_lpm_rx) begin
      if (!i_linkstate_ok) begin
        hs_nxt = `ULPM_HS_STALL;
        set_v[`ULPM_BIT_ERR] = 1'b1;
        set_v[`ULPM_BIT_STALL] = 1'b1;
      end else if (pending_s) begin
        hs_nxt = `ULPM_HS_NYET;
        set_v[`ULPM_BIT_NC] = 1'b1;
        set_v[`ULPM_BIT_NYET] = 1'b1;
      end else begin
        hs_nxt = `ULPM_HS_ACK;
        set_v[`ULPM_BIT_ACK] = 1'b1;
      end
    end
    if (i_host_mode && i_lpm_tx_done) begin
      if (i_peer_hs == `ULPM_HS_ACK) begin
        set_v[`ULPM_BIT_NC] = 1'b1;
        set_v[`ULPM_BIT_ACK] = 1'b1;
      end else if (i_peer_hs == `ULPM_HS_NYET) begin
        set_v[`ULPM_BIT_NYET] = 1'b1;
      end else if (i_peer_hs == `ULPM_HS_STALL) begin
        set_v[`ULPM_BIT_STALL] = 1'b1;
      end
    end
    if (susp_d_r && !suspended_s) begin
      set_v[`ULPM_BIT_RES] = 1'b1;
    end
  end

  // Software clears flags by writing ones to the event register.
  always @* begin
    clr_v = 6'h00;
    if (state_r == ST_DATA && wr_r && addr_r == `ULPM_OFF_EVENT) begin
      clr_v = i_hwdata[5:0];
    end
    flags_nxt = (flags_r & ~clr_v) | set_v;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      wr_r <= 1'b0;
      addr_r <= 12'h000;
      addr_fld_r <= `ULPM_RST_ADDR;
      flags_r <= `ULPM_RST_FLAGS;
      susp_d_r <= 1'b0;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hs_valid <= 1'b0;
      o_hs_code <= `ULPM_HS_NONE;
      o_lpm_function_address <= `ULPM_RST_ADDR;
    end else if (i_ce) begin
      susp_d_r <= suspended_s;
      flags_r <= flags_nxt;
      o_hs_valid <= (hs_nxt != `ULPM_HS_NONE);
      o_hs_code <= hs_nxt;
      case (state_r)
        ST_IDLE: begin
          if (i_hsel && i_hready && i_htrans[1]) begin
            state_r <= ST_DATA;
            wr_r <= i_hwrite;
            addr_r <= {i_haddr[11:2], 2'b00};
          end
        end
        default: begin
          state_r <= ST_IDLE;
          if (wr_r && (addr_r == `ULPM_OFF_STATUS || addr_r == `ULPM_OFF_CTRL)) begin
            addr_fld_r <= i_hwdata[`ULPM_ADDR_MSB:`ULPM_ADDR_LSB];
            o_lpm_function_address <= i_hwdata[`ULPM_ADDR_MSB:`ULPM_ADDR_LSB];
          end
        end
      endcase
      // Read data are registered at the address phase for a zero-wait answer.
      if (state_r == ST_IDLE && i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
        if (i_haddr[11:2] == `ULPM_OFF_STATUS >> 2) begin
          o_hrdata <= status_word(addr_fld_r, flags_nxt);
        end else if (i_haddr[11:2] == `ULPM_OFF_EVENT >> 2) begin
          o_hrdata <= {26'h0000000, flags_nxt};
        end else if (i_haddr[11:2] == `ULPM_OFF_CTRL >> 2) begin
          o_hrdata <= status_word(addr_fld_r, 6'h00);
        end else begin
          o_hrdata <= 32'h00000000;
        end
      end
    end
  end
endmodule // ulpm_status

// *** logic/ulpm_sync.v ***
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module ulpm_sync #(
  parameter W = 4
) (
  // Clock and reset.
  input wire i_clock,
  input wire i_rst,
  input wire i_ce,
  // Levels in and out.
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_r;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // ulpm_sync

// *** tb/ulpm_peer.sv ***
// USB peer model driving LPM tokens and handshakes.
`timescale 1ns/1ps
module ulpm_peer (input wire i_clock, output reg o_rx = 0, o_dn = 0,
  output wire o_ok, output wire [1:0] o_hs);
  reg a = 0;
  reg [1:0] v = 0, c = 0;
  always @(posedge i_clock) c <= c + 1;
  // Qualifiers change every cycle outside an event.
  assign o_ok = a ? v[0] : c[0];
  assign o_hs = a ? v : c;
  task send(input [1:0] h, input t);
    a <= 1; v <= h; o_rx <= !t; o_dn <= t; @(posedge i_clock); a <= 0; o_rx <= 0; o_dn <= 0;
  endtask
endmodule // ulpm_peer

// *** tb/ulpm_status_monitor.sv ***
// Port assertions for the LPM status block.
`timescale 1ns/1ps
module ulpm_status_monitor (input wire i_clock, i_rst, i_ce, i_hwrite, i_host_mode, i_lpm_rx,
  i_linkstate_ok, o_hs_valid, input wire [1:0] i_htrans, o_hs_code,
  input wire [11:0] i_haddr, input wire [31:0] i_hwdata, o_hrdata,
  input wire [6:0] o_lpm_function_address);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_ce);
  wire rd = i_htrans[1] && !i_hwrite;
  wire r0 = rd && i_haddr == 0;
  wire dv = i_lpm_rx && !i_host_mode;
  sequence s_wr; i_htrans[1] && i_hwrite && i_haddr == 0 ##1 1; endsequence
  sequence s_rr; r0 ##2 r0; endsequence
  property p_adr; s_wr |=> o_lpm_function_address == $past(i_hwdata[14:8]); endproperty
  a_adr: assert property (p_adr) else $error("addr");
  property p_rda; r0 |=> o_hrdata[14:8] == o_lpm_function_address; endproperty
  a_rda: assert property (p_rda) else $error("addr read");
  property p_err; dv && !i_linkstate_ok |=> o_hs_valid && o_hs_code == 2; endproperty
  a_err: assert property (p_err) else $error("stall");
  property p_ok; dv && i_linkstate_ok |=> o_hs_valid && o_hs_code < 2; endproperty
  a_ok: assert property (p_ok) else $error("ack");
  property p_one; !dv |=> !o_hs_valid; endproperty
  a_one: assert property (p_one) else $error("pulse");
  property p_hst; i_host_mode && i_lpm_rx |=> !o_hs_valid; endproperty
  a_hst: assert property (p_hst) else $error("host");
  property p_unu; rd && i_haddr < 8 |=> o_hrdata[31:15] == 0 && o_hrdata[7:6] == 0; endproperty
  a_unu: assert property (p_unu) else $error("unused");
  property p_stk; s_rr |=> (o_hrdata[5:0] & $past(o_hrdata[5:0], 2)) == $past(o_hrdata[5:0], 2);
  endproperty
  a_stk: assert property (p_stk) else $error("sticky");
endmodule // ulpm_status_monitor
bind ulpm_status ulpm_status_monitor u_mon (.*);

// *** tb/ulpm_status_test.sv ***
// Self-checking bench for the LPM status block.
`timescale 1ns/1ps
module ulpm_status_test;
  reg i_clock = 0, i_rst = 1, i_host_mode = 0, i_suspended = 0, i_rx_fifo_pending = 0, i_ce = 1;
  reg i_hwrite = 0, p = 0; reg [1:0] i_htrans = 0; reg [11:0] i_haddr = 0;
  reg [31:0] i_hwdata = 0, d, s = 66264; logic [31:0] rq[$]; logic [1:0] hq[$];
  wire o_hreadyout, o_hs_valid, rx, dn, ok; wire [1:0] o_hs_code, hs; wire [31:0] o_hrdata;
  wire o_hresp; wire [6:0] o_lpm_function_address;
  int fails = 0, tests_run = 0;
  ulpm_status DUT (.*, .i_hsel(1'b1), .i_hsize(3'h2), .i_hready(o_hreadyout),
    .i_lpm_rx(rx), .i_linkstate_ok(ok), .i_lpm_tx_done(dn), .i_peer_hs(hs));
  ulpm_peer peer (.i_clock, .o_rx(rx), .o_dn(dn), .o_ok(ok), .o_hs(hs));
  initial forever #4 i_clock = ~i_clock;
  function logic [31:0] xs(); s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s; endfunction
  task chk_rd(input logic [31:0] e); tests_run++;
    if ($isunknown(e) || o_hrdata !== e) begin
      fails++; $display("wrong value hrdata %h %h", e, o_hrdata);
    end
    if (o_hresp !== 1'b0) begin fails++; $display("wrong value hresp 0 %b", o_hresp); end
  endtask
  task chk_hs(input logic [1:0] e); tests_run++;
    if ($isunknown(e) || o_hs_code !== e) begin
      fails++; $display("wrong value hs_code %h %h", e, o_hs_code);
    end
  endtask
  task chk_fa(input logic [6:0] e); tests_run++;
    if (o_lpm_function_address !== e) begin
      fails++; $display("wrong value function_address %h %h", e, o_lpm_function_address);
    end
  endtask
  always @(posedge i_clock) begin
    if (p) chk_rd(rq.size() ? rq.pop_front() : 'x);
    if (!i_rst && o_hs_valid !== 0) chk_hs(hq.size() ? hq.pop_front() : 'x);
    p <= i_htrans[1] && !i_hwrite;
  end
  task wt; int n; n = 0;
    do begin @(posedge i_clock); n++; end while (o_hreadyout !== 1 && n < 50);
    if (o_hreadyout !== 1'b1) begin fails++; wrap_up; end
  endtask
  task bus(input w, input [11:0] a, input [31:0] v, input [31:0] e);
    if (!w) rq.push_back(e);
    i_haddr <= a; i_hwrite <= w; i_htrans <= 2; wt; i_htrans <= 0; i_hwdata <= v; wt;
  endtask
  task wrap_up;
    if (hq.size() || rq.size()) fails++;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 0;
    bus(0, 0, 0, 0);
    d = xs();
    bus(1, 0, d, 0);
    bus(0, 0, 0, {17'h0, d[14:8], 8'h0});
    chk_fa(d[14:8]);
    hq.push_back(2);
    peer.send(0, 0);
    bus(0, 4, 0, 'h21);
    bus(1, 4, 'h3f, 0);
    hq.push_back(0);
    peer.send(1, 0);
    i_rx_fifo_pending <= 1;
    repeat (3) @(posedge i_clock);
    hq.push_back(1);
    peer.send(1, 0);
    repeat (2) bus(0, 0, 0, {17'h0, d[14:8], 8'he});
    i_host_mode <= 1;
    peer.send(1, 0);
    for (int i = 0; i < 3; i++) begin
      bus(1, 4, 'h3f, 0);
      peer.send(i, 1);
      bus(0, 4, 0, i ? 2 >> (i - 1) : 'hc);
    end
    bus(1, 4, 'h3f, 0);
    i_suspended <= 1;
    repeat (4) @(posedge i_clock);
    i_suspended <= 0;
    repeat (5) @(posedge i_clock);
    bus(0, 4, 0, 'h10);
    i_ce <= 0;
    peer.send(0, 1);
    i_ce <= 1;
    bus(0, 4, 0, 'h10);
    d = xs();
    bus(1, 8, d, 0);
    bus(0, 8, 0, {17'h0, d[14:8], 8'h0});
    bus(0, 0, 0, {17'h0, d[14:8], 8'h10});
    bus(0, 'hc, 0, 0);
    chk_fa(d[14:8]);
    repeat (2) @(posedge i_clock);
    wrap_up;
  end
endmodule // ulpm_status_test
